// File: timer_counter_map.svh
`ifndef TIMER_COUNTER_MAP_SVH
`define TIMER_COUNTER_MAP_SVH
`define TC_CH_STRIDE_SHIFT 6
`define TC_OFF_CCR 6'h00
`define TC_OFF_CMR 6'h04
`define TC_OFF_CV 6'h10
`define TC_OFF_RB 6'h18
`define TC_OFF_RC 6'h1C
`define TC_OFF_SR 6'h20
`define TC_OFF_IMR 6'h2C
`define TC_ADDR_BCR 8'hC0
`define TC_ADDR_BMR 8'hC4
`define CHANNEL_CONTROL_REG_CLOCK_ENABLE_CMD 0
`define CHANNEL_CONTROL_REG_CLOCK_DISABLE_CMD 1
`define CHANNEL_CONTROL_REG_SOFTWARE_TRIGGER_BIT 2
`define BLOCK_CONTROL_REG_SYNC 0
`define CHANNEL_STATUS_REG_CLOCK_ENABLED_FLAG 16
`define CHANNEL_MODE_REG_RESET 20'h00000
`define BLOCK_MODE_REG_RESET 6'h00
`define TC_PRE_W 10
`define TC_PRE_MASKS {10'h3FF, 10'h07F, 10'h01F, 10'h007, 10'h001}
`endif

// File: timer_counter_pkg.sv
package timer_counter_pkg;
	typedef struct packed {
		logic [1:0] ldrb;
		logic wave;
		logic trigger_on_c_match;
		logic disable_on_c_match;
		logic stop_on_c_match;
		logic external_trigger_enable;
		logic [1:0] eevt;
		logic abetrg;
		logic [1:0] trig_edge;
		logic disable_on_b_load;
		logic stop_on_b_load;
		logic [1:0] burst;
		logic clock_invert_bit;
		logic [2:0] clk_sel;
	} channel_mode_t;
	typedef struct packed {
		logic etrg;
		logic ldrb;
		logic cpc;
		logic overflow_flag;
	} channel_flags_t;
	typedef enum logic [2:0] {
		CLK_OFF = 3'b001,
		CLK_STOPPED = 3'b010,
		CLK_RUNNING = 3'b100
	} clock_state_t;
endpackage

// File: timer_counter_channel_core.sv
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "timer_counter_map.svh"
module timer_counter_channel_core
	import timer_counter_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [2:0] i_block_clock_pin,
	input wire logic [2:0] i_multipurpose_line_a,
	input wire logic [2:0] i_multipurpose_line_b,
	output logic [2:0] o_multipurpose_line_a,
	output logic [2:0] o_multipurpose_line_a_oe,
	output logic [2:0] o_multipurpose_line_b,
	output logic [2:0] o_multipurpose_line_b_oe,
	output logic [2:0] o_irq
);
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
		$error("CNT_W out of range");
	end

	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [5*`TC_PRE_W-1:0] PRE_MASKS = `TC_PRE_MASKS;

	function automatic logic edge_hit(input logic lvl, input logic prev, input logic [1:0] sel);
		logic r;
		logic f;
		r = lvl & ~prev;
		f = ~lvl & prev;
		case (sel)
			2'h1: edge_hit = r;
			2'h2: edge_hit = f;
			2'h3: edge_hit = r | f;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic ccr_cmd(input logic wr_sel, input logic [5:0] off, input logic [31:0] d, input int b);
		ccr_cmd = wr_sel && off == `TC_OFF_CCR && d[b];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [8:0] sync1;
	logic [8:0] sync2;
	logic [8:0] sync3;
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
			sync3 <= 9'h000;
		end else begin
			sync1 <= {i_multipurpose_line_b, i_multipurpose_line_a, i_block_clock_pin};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and state
	channel_mode_t mode [3];
	channel_flags_t flags [3];
	logic [3:0] imask [3];
	logic [CNT_W-1:0] cv [3];
	logic [CNT_W-1:0] rc [3];
	logic [CNT_W-1:0] rb [3];
	clock_state_t cstate [3];
	logic [2:0] rst_pend;
	logic [2:0] eq_d;
	logic [2:0] a_out_d;
	logic [5:0] bmr;
	logic [`TC_PRE_W-1:0] pre;

	logic [2:0] pin_lvl;
	logic [2:0] pin_prev;
	logic [2:0] a_lvl;
	logic [2:0] a_prev;
	logic [2:0] b_lvl;
	logic [2:0] b_prev;
	logic [2:0] xc_lvl;
	logic [2:0] xc_prev;
	logic [4:0] pre_tick;
	logic [2:0] tick;
	logic [2:0] trig;
	logic [2:0] cpc_hit;
	logic [2:0] ldb_ev;
	logic [2:0] etrg_ev;
	logic [2:0] ch_wr;
	logic [2:0] sr_rd;
	logic [1:0] ch_idx;
	logic [5:0] ch_off;
	logic sync_pulse;
	logic [2:0] en_cmd;
	logic [2:0] dis_cmd;
	logic [2:0] stop_cmd;
	logic [2:0] wrap_ev;

	assign ch_idx = i_addr[7:`TC_CH_STRIDE_SHIFT];
	assign ch_off = i_addr[`TC_CH_STRIDE_SHIFT-1:0];
	assign pin_lvl = sync2[2:0];
	assign pin_prev = sync3[2:0];
	assign sync_pulse = i_wr && i_addr == `TC_ADDR_BCR && i_wdata[`BLOCK_CONTROL_REG_SYNC];

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pre <= '0;
		end else begin
			pre <= pre + 1'b1;
		end
	end

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pre_tick[i] = (pre & PRE_MASKS[i*`TC_PRE_W +: `TC_PRE_W]) ==
				PRE_MASKS[i*`TC_PRE_W +: `TC_PRE_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock routing and per-channel event decode
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			a_lvl[c] = mode[c].wave ? o_multipurpose_line_a[c] : sync2[3+c];
			a_prev[c] = mode[c].wave ? a_out_d[c] : sync3[3+c];
			b_lvl[c] = sync2[6+c];
			b_prev[c] = sync3[6+c];
		end
		for (int k = 0; k < 3; k++) begin
			case (bmr[2*k +: 2])
				2'h0: begin
					xc_lvl[k] = pin_lvl[k];
					xc_prev[k] = pin_prev[k];
				end
				2'h2: begin
					xc_lvl[k] = a_lvl[k == 0 ? 1 : 0];
					xc_prev[k] = a_prev[k == 0 ? 1 : 0];
				end
				2'h3: begin
					xc_lvl[k] = a_lvl[k == 2 ? 1 : 2];
					xc_prev[k] = a_prev[k == 2 ? 1 : 2];
				end
				default: begin
					xc_lvl[k] = 1'b0;
					xc_prev[k] = 1'b0;
				end
			endcase
		end
		for (int c = 0; c < 3; c++) begin
			logic raw;
			logic gate;
			logic [1:0] xi;
			raw = 1'b0;
			gate = 1'b1;
			xi = 2'h0;
			if (mode[c].clk_sel < 3'h5) begin
				raw = pre_tick[mode[c].clk_sel];
			end else begin
				xi = 2'(mode[c].clk_sel - 3'h5);
				raw = edge_hit(xc_lvl[xi], xc_prev[xi], mode[c].clock_invert_bit ? 2'h2 : 2'h1);
			end
			if (mode[c].burst != 2'h0) begin
				gate = xc_lvl[2'(mode[c].burst - 2'h1)];
			end
			tick[c] = raw & gate;
			cpc_hit[c] = (cv[c] == rc[c]) && !eq_d[c];
			ldb_ev[c] = !mode[c].wave && edge_hit(a_lvl[c], a_prev[c], mode[c].ldrb);
			if (!mode[c].wave) begin
				etrg_ev[c] = mode[c].abetrg ? edge_hit(a_lvl[c], a_prev[c], mode[c].trig_edge)
					: edge_hit(b_lvl[c], b_prev[c], mode[c].trig_edge);
			end else if (mode[c].eevt == 2'h0) begin
				etrg_ev[c] = edge_hit(b_lvl[c], b_prev[c], mode[c].trig_edge);
			end else begin
				etrg_ev[c] = edge_hit(xc_lvl[2'(mode[c].eevt - 2'h1)],
					xc_prev[2'(mode[c].eevt - 2'h1)], mode[c].trig_edge);
			end
			ch_wr[c] = i_wr && ch_idx == 2'(c);
			sr_rd[c] = i_rd && ch_idx == 2'(c) && ch_off == `TC_OFF_SR;
			trig[c] = (ch_wr[c] && ch_off == `TC_OFF_CCR && i_wdata[`CHANNEL_CONTROL_REG_SOFTWARE_TRIGGER_BIT])
				| sync_pulse
				| (mode[c].trigger_on_c_match && cpc_hit[c])
				| (etrg_ev[c] && (!mode[c].wave || mode[c].external_trigger_enable));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bmr <= `BLOCK_MODE_REG_RESET;
			for (int c = 0; c < 3; c++) begin
				mode[c] <= `CHANNEL_MODE_REG_RESET;
				rc[c] <= '0;
				imask[c] <= 4'h0;
			end
		end else begin
			if (i_wr && i_addr == `TC_ADDR_BMR) begin
				bmr <= i_wdata[5:0];
			end
			for (int c = 0; c < 3; c++) begin
				if (ch_wr[c] && ch_off == `TC_OFF_CMR) begin
					mode[c] <= i_wdata[19:0];
				end
				if (ch_wr[c] && ch_off == `TC_OFF_RC) begin
					rc[c] <= i_wdata[CNT_W-1:0];
				end
				if (ch_wr[c] && ch_off == `TC_OFF_IMR) begin
					imask[c] <= i_wdata[3:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Enable, disable, stop and wrap decode
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			en_cmd[c] = ccr_cmd(ch_wr[c], ch_off, i_wdata, `CHANNEL_CONTROL_REG_CLOCK_ENABLE_CMD)
				&& !ccr_cmd(ch_wr[c], ch_off, i_wdata, `CHANNEL_CONTROL_REG_CLOCK_DISABLE_CMD);
			dis_cmd[c] = ccr_cmd(ch_wr[c], ch_off, i_wdata, `CHANNEL_CONTROL_REG_CLOCK_DISABLE_CMD)
				| (ldb_ev[c] && mode[c].disable_on_b_load)
				| (mode[c].wave && cpc_hit[c] && mode[c].disable_on_c_match);
			stop_cmd[c] = (ldb_ev[c] && mode[c].stop_on_b_load)
				| (mode[c].wave && cpc_hit[c] && mode[c].stop_on_c_match);
			wrap_ev[c] = cstate[c] == CLK_RUNNING && tick[c] && !rst_pend[c] && cv[c] == CNT_MAX;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock control
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int c = 0; c < 3; c++) begin
				cstate[c] <= CLK_OFF;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				unique case (cstate[c])
					CLK_OFF: begin
						if (en_cmd[c] && !dis_cmd[c]) begin
							cstate[c] <= trig[c] ? CLK_RUNNING : CLK_STOPPED;
						end
					end
					CLK_STOPPED, CLK_RUNNING: begin
						if (dis_cmd[c]) begin
							cstate[c] <= CLK_OFF;
						end else if (trig[c]) begin
							cstate[c] <= CLK_RUNNING;
						end else if (stop_cmd[c]) begin
							cstate[c] <= CLK_STOPPED;
						end
					end
					default: cstate[c] <= CLK_OFF;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counters and capture B
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rst_pend <= 3'h0;
			for (int c = 0; c < 3; c++) begin
				cv[c] <= '0;
				rb[c] <= '0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				logic counting;
				counting = cstate[c] == CLK_RUNNING && tick[c];
				if (counting) begin
					cv[c] <= rst_pend[c] ? '0 : cv[c] + 1'b1;
				end
				// Enable written with a trigger also resets the count
				if (trig[c] && (cstate[c] != CLK_OFF || (en_cmd[c] && !dis_cmd[c]))) begin
					rst_pend[c] <= 1'b1;
				end else if (counting) begin
					rst_pend[c] <= 1'b0;
				end
				if (ldb_ev[c]) begin
					rb[c] <= cv[c];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Match and line A history; match starts set so reset gives no false compare
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			eq_d <= 3'h7;
			a_out_d <= 3'h0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				eq_d[c] <= cv[c] == rc[c];
				a_out_d[c] <= o_multipurpose_line_a[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status flags, set wins over read clear
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int c = 0; c < 3; c++) begin
				flags[c] <= 4'h0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				flags[c].overflow_flag <= wrap_ev[c] | (flags[c].overflow_flag & ~sr_rd[c]);
				flags[c].cpc <= cpc_hit[c] | (flags[c].cpc & ~sr_rd[c]);
				flags[c].ldrb <= ldb_ev[c] | (flags[c].ldrb & ~sr_rd[c]);
				flags[c].etrg <= etrg_ev[c] | (flags[c].etrg & ~sr_rd[c]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins and interrupts
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_multipurpose_line_a <= 3'h0;
			o_multipurpose_line_a_oe <= 3'h0;
			o_multipurpose_line_b <= 3'h0;
			o_multipurpose_line_b_oe <= 3'h0;
			o_irq <= 3'h0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				o_multipurpose_line_a_oe[c] <= mode[c].wave;
				o_multipurpose_line_b_oe[c] <= mode[c].wave && mode[c].eevt != 2'h0;
				if (!mode[c].wave) begin
					o_multipurpose_line_a[c] <= 1'b0;
					o_multipurpose_line_b[c] <= 1'b0;
				end else if (cpc_hit[c]) begin
					o_multipurpose_line_a[c] <= ~o_multipurpose_line_a[c];
					o_multipurpose_line_b[c] <= ~o_multipurpose_line_b[c];
				end
				o_irq[c] <= |(flags[c] & imask[c]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= 32'h00000000;
		end else begin
			o_rdata <= 32'h00000000;
			if (i_rd) begin
				if (i_addr == `TC_ADDR_BMR) begin
					o_rdata <= {26'h0, bmr};
				end else if (ch_idx != 2'h3) begin
					case (ch_off)
						`TC_OFF_CMR: o_rdata <= {12'h000, mode[ch_idx]};
						`TC_OFF_CV: o_rdata <= 32'(cv[ch_idx]);
						`TC_OFF_RB: o_rdata <= 32'(rb[ch_idx]);
						`TC_OFF_RC: o_rdata <= 32'(rc[ch_idx]);
						`TC_OFF_IMR: o_rdata <= {28'h0000000, imask[ch_idx]};
						`TC_OFF_SR: begin
							o_rdata <= {28'h0000000, flags[ch_idx]};
							o_rdata[`CHANNEL_STATUS_REG_CLOCK_ENABLED_FLAG] <= cstate[ch_idx] != CLK_OFF;
						end
						default: o_rdata <= 32'h00000000;
					endcase
				end
			end
		end
	end
endmodule

// File: tc_core_sva.sv
`timescale 1ns/1ps
module tc_core_sva(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [2:0] o_multipurpose_line_a_oe,
	input wire logic [2:0] o_multipurpose_line_b_oe,
	input wire logic [2:0] o_irq
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	logic [2:0] wave;
	logic [2:0] evb;
	logic [3:0] mask0;
	// Shadow of mode and mask writes
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wave <= 3'h0;
			evb <= 3'h0;
			mask0 <= 4'h0;
		end else if (i_wr) begin
			if (i_addr[5:0] == 6'h04 && i_addr[7:6] != 2'h3) begin
				wave[i_addr[7:6]] <= i_wdata[17];
				evb[i_addr[7:6]] <= |i_wdata[12:11];
			end
			if (i_addr == 8'h2C)
				mask0 <= i_wdata[3:0];
		end
	end
	////////////////////////////////////////////////////////////
	sequence ccr_wr(b);
		i_wr && i_addr == 8'h00 && i_wdata[2:0] == b;
	endsequence
	sequence sr_rd;
		i_rd && i_addr == 8'h20;
	endsequence
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not idle");
	unmapped_rd_a: assert property (i_rd && i_addr == 8'h08 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	clk_en_flag_a: assert property (ccr_wr(3'h1) ##1 sr_rd |=> o_rdata[16])
		else $error("enabled flag missing");
	clk_dis_flag_a: assert property (ccr_wr(3'h2) ##1 sr_rd |=> !o_rdata[16])
		else $error("disable ignored");
	bmr_back_a: assert property (i_wr && i_addr == 8'hC4 ##1 i_rd && i_addr == 8'hC4
		|=> o_rdata[5:0] == $past(i_wdata[5:0], 2)) else $error("block mode readback wrong");
	line_a_oe_a: assert property (wave == $past(wave) |-> o_multipurpose_line_a_oe == wave)
		else $error("line a direction wrong");
	line_b_oe_a: assert property (wave == $past(wave) && evb == $past(evb)
		|-> o_multipurpose_line_b_oe == (wave & evb)) else $error("line b direction wrong");
	irq_mask_a: assert property (mask0 == 4'h0 && $past(mask0) == 4'h0 |-> !o_irq[0])
		else $error("masked interrupt raised");
endmodule
bind timer_counter_channel_core tc_core_sva chk_u(.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .o_multipurpose_line_a_oe, .o_multipurpose_line_b_oe, .o_irq);

// File: ext_pins_model.sv
`timescale 1ns/1ps
module ext_pins_model(
	input wire logic i_clk_sys,
	input wire logic i_run,
	input wire logic i_gate,
	input wire logic i_trig,
	input wire logic [2:0] i_a_out,
	input wire logic [2:0] i_a_oe,
	input wire logic [2:0] i_b_out,
	input wire logic [2:0] i_b_oe,
	output logic [2:0] o_pins,
	output logic [2:0] o_line_a,
	output logic [2:0] o_line_b
);
	logic [1:0] ph = 2'h0;
	logic ck = 1'h0;
	// Three master periods a level, still low outside runs
	always_ff @(posedge i_clk_sys) begin
		if (!i_run || ph == 2'h2)
			ph <= 2'h0;
		else
			ph <= ph + 2'h1;
		if (!i_run)
			ck <= 1'h0;
		else if (ph == 2'h2)
			ck <= !ck;
	end
	assign o_pins = {1'h0, i_gate, ck};
	assign o_line_a = (i_a_oe & i_a_out) | (~i_a_oe & {2'h0, i_trig});
	assign o_line_b = i_b_oe & i_b_out;
endmodule

// File: timer_counter_channel_core_tb.sv
`timescale 1ns/1ps
module timer_counter_channel_core_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic run = 1'h0;
	logic gate = 1'h0;
	logic trig = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, v0, v1, v2;
	logic [2:0] pins, la, lb, ao, aoe, bo, boe, irq;
	int err_count = 0;
	int n_compared = 0;
	timer_counter_channel_core dut_u(.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_block_clock_pin(pins), .i_multipurpose_line_a(la),
		.i_multipurpose_line_b(lb), .o_multipurpose_line_a(ao), .o_multipurpose_line_a_oe(aoe),
		.o_multipurpose_line_b(bo), .o_multipurpose_line_b_oe(boe), .o_irq(irq));
	ext_pins_model pins_u(.i_clk_sys(clk), .i_run(run), .i_gate(gate), .i_trig(trig), .i_a_out(ao),
		.i_a_oe(aoe), .i_b_out(bo), .i_b_oe(boe), .o_pins(pins), .o_line_a(la), .o_line_b(lb));
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h0;
		repeat (n - 1) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		rd <= 1'h0;
		addr <= a;
		wdata <= d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 q = rdata;
	endtask
	// Count across n whole pin clock periods
	task automatic pulses(input int n, input logic [31:0] exp, input logic fresh);
		rd_reg(8'h10, v0);
		wt(1);
		run <= 1'h1;
		repeat (6 * n) @(posedge clk);
		run <= 1'h0;
		wt(8);
		rd_reg(8'h10, v1);
		chk(fresh ? v1 : v1 - v0, exp);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd_reg(8'h10, v0);
		chk(v0, 32'h0);
		wr_reg(8'hC4, 32'h39);
		rd_reg(8'hC4, v0);
		chk(v0, 32'h39);
		wr_reg(8'h44, 32'hFFFFF);
		rd_reg(8'h44, v0);
		chk(v0, 32'hFFFFF);
		wr_reg(8'h44, 32'h0);
		wr_reg(8'hC4, 32'h0);
		rd_reg(8'h08, v0);
		chk(v0, 32'h0);
		$display("regs done");
	endtask
	task automatic t_div;
		int dv[5] = '{2, 8, 32, 128, 1024};
		for (int k = 0; k < 5; k++) begin
			wr_reg(8'h04, 32'(k));
			wr_reg(8'h00, 32'h5);
			wt(2 * dv[k]);
			rd_reg(8'h10, v0);
			wt(2 * dv[k] - 2);
			rd_reg(8'h10, v1);
			chk(v1 - v0, 32'h2);
		end
		wr_reg(8'h00, 32'h1);
		rd_reg(8'h20, v0);
		chk(v0 & 32'h10000, 32'h10000);
		wr_reg(8'h00, 32'h2);
		rd_reg(8'h20, v0);
		chk(v0 & 32'h10000, 32'h0);
		rd_reg(8'h10, v0);
		wr_reg(8'h00, 32'h4);
		wt(20);
		rd_reg(8'h10, v1);
		chk(v1, v0);
		$display("div done");
	endtask
	task automatic t_cmatch;
		wr_reg(8'h04, 32'h24000);
		wr_reg(8'h1C, 32'h5);
		wr_reg(8'h2C, 32'h2);
		wr_reg(8'h00, 32'h5);
		wt(40);
		rd_reg(8'h10, v0);
		chk(v0, 32'h5);
		chk({29'h0, irq}, 32'h1);
		rd_reg(8'h20, v0);
		chk(v0, 32'h10002);
		wt(3);
		chk({29'h0, irq}, 32'h0);
		wr_reg(8'h04, 32'h30000);
		wr_reg(8'h00, 32'h5);
		for (int i = 0; i < 8; i++) begin
			rd_reg(8'h10, v0);
			chk({31'h0, v0 > 32'h5}, 32'h0);
		end
		wr_reg(8'h04, 32'h28000);
		wr_reg(8'h00, 32'h5);
		wt(40);
		rd_reg(8'h20, v0);
		chk(v0 & 32'h10000, 32'h0);
		$display("cmatch done");
	endtask
	task automatic t_ext;
		wr_reg(8'h04, 32'h5);
		wr_reg(8'h00, 32'h5);
		pulses(1, 32'h0, 1'h1);
		pulses(5, 32'h5, 1'h0);
		wr_reg(8'h04, 32'hD);
		wr_reg(8'h00, 32'h5);
		pulses(1, 32'h0, 1'h1);
		pulses(4, 32'h4, 1'h0);
		wr_reg(8'h04, 32'h25);
		pulses(3, 32'h0, 1'h0);
		gate <= 1'h1;
		wt(6);
		pulses(3, 32'h3, 1'h0);
		$display("ext done");
	endtask
	task automatic t_sync;
		wr_reg(8'h04, 32'h0);
		for (int c = 0; c < 3; c++) begin
			wr_reg({c[1:0], 6'h00}, 32'h2);
			wr_reg({c[1:0], 6'h00}, 32'h1);
		end
		rd_reg(8'h10, v0);
		wt(10);
		rd_reg(8'h10, v1);
		chk(v1, v0);
		wr_reg(8'hC0, 32'h1);
		wt(20);
		rd_reg(8'h10, v0);
		rd_reg(8'h50, v1);
		rd_reg(8'h90, v2);
		chk(v1, v0 + 32'h1);
		chk(v2, v0 + 32'h2);
		wr_reg(8'h04, 32'h500);
		wr_reg(8'h00, 32'h2);
		wr_reg(8'h00, 32'h1);
		rd_reg(8'h10, v0);
		trig <= 1'h1;
		wt(20);
		rd_reg(8'h10, v1);
		chk({31'h0, v1 == v0}, 32'h0);
		$display("sync done");
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_div;
		t_cmatch;
		t_ext;
		t_sync;
		finish_test;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		finish_test;
	end
endmodule
